// ==== logic/rr_sbc_top.sv ====
// Purpose: AXI4-Lite wrapper that runs rotate and subtract ops on data memory
// Assumes: single clock, synchronous active-low reset, one write and one read in flight
// Notes: a command runs in two cycles; writes are refused while one runs
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
module rr_sbc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [rr_sbc_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [rr_sbc_pkg::BUS_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [rr_sbc_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [rr_sbc_pkg::BUS_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic busy
);
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_fetch = 2'b01,
		st_exec = 2'b10
	} state_t;

	// Word-aligned and inside the map
	function automatic logic is_mapped(input logic [rr_sbc_pkg::ADDR_W-1:0] a);
		is_mapped = (a[1:0] == 2'b00) && (a <= rr_sbc_pkg::OFS_STAT);
	endfunction

	// Flag word, read layout and map are laid out for byte operands on a 32-bit bus
	// byte-wide operands
	if (rr_sbc_pkg::DATA_W != 8 || rr_sbc_pkg::BUS_W != 32) begin
		$error("rr_sbc_top: unsupported data or bus width");
	end

	// The pointer is loaded from one data byte and the map must fit the address
	if (rr_sbc_pkg::MEM_AW > rr_sbc_pkg::DATA_W || rr_sbc_pkg::ADDR_W < 5) begin
		$error("rr_sbc_top: unsupported address width");
	end

	// Register state
	state_t st_q;
	state_t st_d;
	rr_sbc_pkg::op_t op_q;
	rr_sbc_pkg::op_t op_d;
	logic [rr_sbc_pkg::DATA_W-1:0] acc_q;
	logic [rr_sbc_pkg::DATA_W-1:0] acc_d;
	rr_sbc_pkg::flags_t flags_q;
	rr_sbc_pkg::flags_t flags_d;
	logic [rr_sbc_pkg::MEM_AW-1:0] ptr_q;
	logic [rr_sbc_pkg::MEM_AW-1:0] ptr_d;

	// Bus state
	logic aw_hold_q;
	logic aw_hold_d;
	logic [rr_sbc_pkg::ADDR_W-1:0] waddr_q;
	logic [rr_sbc_pkg::ADDR_W-1:0] waddr_d;
	logic w_hold_q;
	logic w_hold_d;
	logic [rr_sbc_pkg::BUS_W-1:0] wword_q;
	logic [rr_sbc_pkg::BUS_W-1:0] wword_d;
	logic wlane_q;
	logic wlane_d;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;
	logic rvalid_q;
	logic rvalid_d;
	logic [rr_sbc_pkg::BUS_W-1:0] rdata_q;
	logic [rr_sbc_pkg::BUS_W-1:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;

	// Memory and datapath wires
	logic mem_we;
	logic [rr_sbc_pkg::MEM_AW-1:0] mem_waddr;
	logic [rr_sbc_pkg::DATA_W-1:0] mem_wdata;
	logic [rr_sbc_pkg::DATA_W-1:0] mem_rdata;
	rr_sbc_pkg::alu_out_t alu_res;

	// Write commit and op decode helpers
	logic do_write;
	logic wr_ok;
	logic [rr_sbc_pkg::DATA_W-1:0] wbyte;
	rr_sbc_pkg::op_t wr_op;

	rr_sbc_mem #(
		.AW(rr_sbc_pkg::MEM_AW),
		.DW(rr_sbc_pkg::DATA_W)
	) u_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(ptr_q),
		.rdata(mem_rdata)
	);

	rr_sbc_alu u_alu (
		.op(op_q),
		.acc(acc_q),
		.operand(mem_rdata),
		.flags_in(flags_q),
		.res(alu_res)
	);

	// Handshake outputs: take each channel once, hold until committed
	// Only one read is outstanding, so arready just follows the empty answer slot
	assign awready = !aw_hold_q;
	assign wready = !w_hold_q;
	assign arready = !rvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign busy = (st_q != st_idle);

	// Commit once both halves are held and the last response is gone
	always_comb begin
		do_write = aw_hold_q && w_hold_q && !bvalid_q;
		wbyte = wword_q[rr_sbc_pkg::DATA_W-1:0];
		wr_op = rr_sbc_pkg::op_t'(wword_q[2:0]);
		// Writes during a command would race the datapath, so refuse them
		wr_ok = is_mapped(waddr_q) && (st_q == st_idle) && (waddr_q != rr_sbc_pkg::OFS_STAT);
		if (waddr_q == rr_sbc_pkg::OFS_CMD && wlane_q && wr_op == rr_sbc_pkg::op_illegal) begin
			wr_ok = 1'b0;
		end
	end

	// Memory write port: bus writes while idle, results in exec
	// Bus writes are refused while busy, so the two users never collide
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = ptr_q;
		mem_wdata = wbyte;
		if (st_q == st_exec) begin
			mem_we = alu_res.to_mem;
			mem_wdata = alu_res.result;
		end else if (do_write && wr_ok && wlane_q && waddr_q == rr_sbc_pkg::OFS_MEMDATA) begin
			mem_we = 1'b1;
		end
	end

	// Write channel next state
	always_comb begin
		aw_hold_d = aw_hold_q;
		waddr_d = waddr_q;
		w_hold_d = w_hold_q;
		wword_d = wword_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (awvalid && !aw_hold_q) begin
			aw_hold_d = 1'b1;
			waddr_d = awaddr;
		end
		if (wvalid && !w_hold_q) begin
			w_hold_d = 1'b1;
			wword_d = wdata;
			wlane_d = wstrb[0];
		end
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		if (do_write) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_ok ? rr_sbc_pkg::RESP_OKAY : rr_sbc_pkg::RESP_SLVERR;
		end
	end

	// Read channel next state, answered the cycle after address
	// Memory data come from the registered port and lag a pointer write by one cycle
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
		if (arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d = is_mapped(araddr) ? rr_sbc_pkg::RESP_OKAY : rr_sbc_pkg::RESP_SLVERR;
			rdata_d = '0;
			unique case (araddr)
				rr_sbc_pkg::OFS_ACC: rdata_d[rr_sbc_pkg::DATA_W-1:0] = acc_q;
				rr_sbc_pkg::OFS_FLAGS: rdata_d[5:0] = flags_q;
				rr_sbc_pkg::OFS_PTR: rdata_d[rr_sbc_pkg::MEM_AW-1:0] = ptr_q;
				rr_sbc_pkg::OFS_CMD: rdata_d[2:0] = op_q;
				rr_sbc_pkg::OFS_MEMDATA: rdata_d[rr_sbc_pkg::DATA_W-1:0] = mem_rdata;
				rr_sbc_pkg::OFS_STAT: rdata_d[3:0] = {op_q, busy};
				default: rdata_d = '0;
			endcase
		end
	end

	// Sequencer and architectural registers
	// Exec overwrites the whole flag word; untouched flags pass through the datapath
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		acc_d = acc_q;
		flags_d = flags_q;
		ptr_d = ptr_q;
		unique case (st_q)
			st_idle: begin
				if (do_write && wr_ok && wlane_q) begin
					unique case (waddr_q)
						rr_sbc_pkg::OFS_ACC: acc_d = wbyte;
						rr_sbc_pkg::OFS_FLAGS: flags_d = wbyte[5:0];
						rr_sbc_pkg::OFS_PTR: ptr_d = wbyte[rr_sbc_pkg::MEM_AW-1:0];
						rr_sbc_pkg::OFS_CMD: begin
							op_d = wr_op;
							// A no-op code only records itself
							if (wr_op != rr_sbc_pkg::op_none) begin
								st_d = st_fetch;
							end
						end
						default: st_d = st_q;
					endcase
				end
			end
			// Read register needs one cycle for the pointer
			st_fetch: st_d = st_exec;
			st_exec: begin
				if (alu_res.to_acc) begin
					acc_d = alu_res.result;
				end
				flags_d = alu_res.flags;
				st_d = st_idle;
			end
			default: st_d = st_idle;
		endcase
	end

	// Sequencer registers; synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= st_idle;
			op_q <= rr_sbc_pkg::op_none;
			acc_q <= rr_sbc_pkg::ACC_RST;
			flags_q <= rr_sbc_pkg::FLAGS_RST;
			ptr_q <= rr_sbc_pkg::PTR_RST;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			acc_q <= acc_d;
			flags_q <= flags_d;
			ptr_q <= ptr_d;
		end
	end

	// Write channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			waddr_q <= '0;
			w_hold_q <= 1'b0;
			wword_q <= '0;
			wlane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= rr_sbc_pkg::RESP_OKAY;
		end else begin
			aw_hold_q <= aw_hold_d;
			waddr_q <= waddr_d;
			w_hold_q <= w_hold_d;
			wword_q <= wword_d;
			wlane_q <= wlane_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	// Read channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= rr_sbc_pkg::RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end
endmodule

// ==== inc/rr_sbc_pkg.sv ====
// Purpose: shared constants and types for the rotate and subtract datapath
// Assumes: 8-bit operands, AXI4-Lite register access with 32-bit data
// Notes: register layout, flag layout and op codes live here only
// Operation
// - Plain rotate right: bit0 goes to bit7, result to memory, flags kept.
// - Rotate right to accumulator: memory kept, flags kept.
// - Rotate through carry: old carry to bit7, bit0 to carry, result to memory.
// - Rotate through carry to accumulator: old bit0 to carry, memory kept.
// - Subtract with borrow: acc minus operand minus inverted carry into accumulator.
// - Same difference written to memory, accumulator untouched.
// - Carry cleared when the difference is negative, set otherwise.
// - Subtracts update overflow, zero, nibble carry, carry, signed compare, chained zero.
package rr_sbc_pkg;
	localparam int DATA_W = 8;
	localparam int BUS_W = 32;
	localparam int ADDR_W = 8;
	localparam int MEM_AW = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_ACC = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PTR = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_MEMDATA = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14;

	// Reset values
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [5:0] FLAGS_RST = 6'h00;
	localparam logic [MEM_AW-1:0] PTR_RST = 4'h0;

	// Bus response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Flag word, carry in bit 0 up to chained zero in bit 5
	typedef struct packed {
		logic chained_null_flag;
		logic signed_compare_flag;
		logic signed_range_exceeded_flag;
		logic zero_flag;
		logic nibble_carry_flag;
		logic carry_flag;
	} flags_t;

	typedef enum logic [2:0] {
		op_none = 3'b000,
		op_rotate_right_mem = 3'b001,
		op_rotate_right_to_acc = 3'b010,
		op_rotate_right_thru_carry = 3'b011,
		op_rotate_right_thru_carry_to_acc = 3'b100,
		op_subtract_borrow_to_acc = 3'b101,
		op_subtract_borrow_to_mem = 3'b110,
		op_illegal = 3'b111
	} op_t;

	// What the datapath hands back for one instruction
	typedef struct packed {
		logic [DATA_W-1:0] result;
		flags_t flags;
		logic to_acc;
		logic to_mem;
	} alu_out_t;
endpackage

// ==== logic/rr_sbc_mem.sv ====
// Purpose: small data memory holding the operands
// Assumes: one write port and one read port on the same clock
// Notes: read data come from a register, one cycle after the address
module rr_sbc_mem #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] store_q [2**AW];
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] rdata_d;

	// Elaboration check: the store is a flat array, so keep it to a sane depth
	if (AW < 1 || AW > 12 || DW < 1) begin
		$error("rr_sbc_mem: unsupported size");
	end

	// Read first: a write shows on the read port one cycle later
	always_comb begin
		rdata_d = store_q[raddr];
	end

	// Contents carry no reset, only the read register does
	always_ff @(posedge aclk) begin
		if (we) begin
			store_q[waddr] <= wdata;
		end
		if (!aresetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;
endmodule

// ==== logic/rr_sbc_alu.sv ====
// Purpose: combinational rotate right and subtract with borrow
// Assumes: op code already checked by the caller
// Notes: flags not touched by an op pass through unchanged
module rr_sbc_alu (
	input wire rr_sbc_pkg::op_t op,
	input wire logic [rr_sbc_pkg::DATA_W-1:0] acc,
	input wire logic [rr_sbc_pkg::DATA_W-1:0] operand,
	input wire rr_sbc_pkg::flags_t flags_in,
	output rr_sbc_pkg::alu_out_t res
);
	// Add two nibbles and a carry, five bits back
	function automatic logic [4:0] nib_add(input logic [3:0] a, input logic [3:0] b,
			input logic ci);
		nib_add = {1'b0, a} + {1'b0, b} + {4'h0, ci};
	endfunction

	logic [4:0] lo;
	logic [4:0] hi;
	logic [7:0] diff;
	logic ovf;

	always_comb begin
		lo = nib_add(acc[3:0], ~operand[3:0], flags_in.carry_flag);
		hi = nib_add(acc[7:4], ~operand[7:4], lo[4]);
		diff = {hi[3:0], lo[3:0]};
		ovf = (acc[7] != operand[7]) && (diff[7] != acc[7]);
	end

	always_comb begin
		res.flags = flags_in;
		res.result = operand;
		res.to_acc = 1'b0;
		res.to_mem = 1'b0;
		unique case (op)
			rr_sbc_pkg::op_rotate_right_mem: begin
				res.result = {operand[0], operand[7:1]};
				res.to_mem = 1'b1;
			end
			rr_sbc_pkg::op_rotate_right_to_acc: begin
				res.result = {operand[0], operand[7:1]};
				res.to_acc = 1'b1;
			end
			rr_sbc_pkg::op_rotate_right_thru_carry: begin
				res.result = {flags_in.carry_flag, operand[7:1]};
				res.flags.carry_flag = operand[0];
				res.to_mem = 1'b1;
			end
			rr_sbc_pkg::op_rotate_right_thru_carry_to_acc: begin
				res.result = {flags_in.carry_flag, operand[7:1]};
				res.flags.carry_flag = operand[0];
				res.to_acc = 1'b1;
			end
			rr_sbc_pkg::op_subtract_borrow_to_acc,
			rr_sbc_pkg::op_subtract_borrow_to_mem: begin
				res.result = diff;
				res.to_acc = (op == rr_sbc_pkg::op_subtract_borrow_to_acc);
				res.to_mem = (op == rr_sbc_pkg::op_subtract_borrow_to_mem);
				res.flags.carry_flag = hi[4];
				res.flags.nibble_carry_flag = lo[4];
				res.flags.zero_flag = (diff == 8'h00);
				res.flags.signed_range_exceeded_flag = ovf;
				res.flags.signed_compare_flag = ovf ^ diff[7];
				res.flags.chained_null_flag = (diff == 8'h00) && flags_in.zero_flag;
			end
			default: begin
				res.result = operand;
			end
		endcase
	end
endmodule

// ==== verification/rr_sbc_checker.sv ====
// Purpose: protocol and timing checks on the datapath wrapper ports
// Assumes: one clock, synchronous active-low reset
// Notes: attached by bind below the module
module rr_sbc_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Answers stand until taken
	property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("bresp dropped early");
	property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("rdata dropped early");
	property p_rupper; rvalid |-> rdata[31:8] == 24'h0; endproperty
	a_rupper: assert property (p_rupper) else $error("rdata upper bits set");
	// Command runs fetch then execute, two cycles
	property p_busy_len; $rose(busy) |=> busy ##1 !busy; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_rd_answer; arvalid && arready |=> rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_rd_drop; rvalid && rready |=> !rvalid; endproperty
	a_rd_drop: assert property (p_rd_drop) else $error("rvalid repeated");
	property p_b_drop; bvalid && bready |=> !bvalid; endproperty
	a_b_drop: assert property (p_b_drop) else $error("bvalid repeated");
	property p_rerr; rvalid && rresp == rr_sbc_pkg::RESP_SLVERR |-> rdata == 32'h0; endproperty
	a_rerr: assert property (p_rerr) else $error("refused read has data");
	c_busy: cover property ($rose(busy));
	c_berr: cover property (bvalid && bresp == rr_sbc_pkg::RESP_SLVERR);
	c_rerr: cover property (rvalid && rresp == rr_sbc_pkg::RESP_SLVERR);
endmodule

bind rr_sbc_top rr_sbc_checker u_chk (.aclk(aclk), .aresetn(aresetn), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
	.bvalid(bvalid), .bready(bready), .bresp(bresp), .busy(busy));

// ==== verification/rotate_right_subtract_borrow_alu_tb.sv ====
// Purpose: self-checking bench for the rotate and subtract wrapper
// Assumes: AXI4-Lite master in this bench, expected values queued
// Notes: a monitor pops expectations as responses appear
module rotate_right_subtract_borrow_alu_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, busy;
	logic [7:0] awaddr, araddr, a, m, ea, em;
	logic [31:0] wdata, rdata, sd;
	logic [1:0] bresp, rresp;
	logic [5:0] f, ef;
	logic [3:0] wstrb;
	logic slow;
	logic [1:0] eb[$];
	logic [33:0] er[$];
	int n_fail, n_tests;
	localparam logic [1:0] OK = rr_sbc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = rr_sbc_pkg::RESP_SLVERR;

	rr_sbc_top u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .busy(busy));

	always #20 aclk = ~aclk;

	function automatic logic [31:0] xs();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd;
	endfunction

	task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic summarize();
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Write: both channels offered together, each released when taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
		eb.push_back(r);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// A slow master raises bready only once the answer stands
		bready <= !slow;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && !bready) bready <= 1'b1;
		end while (!(bvalid && bready));
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] ad, input logic [33:0] e);
		er.push_back(e);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= !slow;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && !rready) rready <= 1'b1;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// Monitor compares each answer with the oldest note
	always @(posedge aclk) begin
		if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, eb.pop_front()});
		if (rvalid && rready) chk("read", {rresp, rdata}, er.pop_front());
	end

	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		summarize();
	end

	initial begin
		logic [8:0] s9;
		logic [4:0] n5;
		logic ov;
		aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
		rready = 0; awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; sd = 32'd79678;
		n_fail = 0; n_tests = 0; wstrb = 4'hf; slow = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(rr_sbc_pkg::OFS_ACC, {OK, 32'h0});
		rd(rr_sbc_pkg::OFS_FLAGS, {OK, 32'h0});
		for (int i = 0; i < 30; i++) begin
			a = 8'(xs());
			m = 8'(xs());
			f = 6'(xs());
			slow = 1'(i % 2);
			if (i % 5 == 0) m = a; // zero difference corner
			wr(rr_sbc_pkg::OFS_ACC, {24'h0, a}, OK);
			wr(rr_sbc_pkg::OFS_FLAGS, {26'h0, f}, OK);
			wr(rr_sbc_pkg::OFS_PTR, 32'(i % 16), OK);
			wr(rr_sbc_pkg::OFS_MEMDATA, {24'h0, m}, OK);
			wr(rr_sbc_pkg::OFS_CMD, 32'(i % 6 + 1), OK);
			while (busy) @(posedge aclk);
			ea = a; em = m; ef = f;
			s9 = {1'b0, a} + {1'b0, ~m} + 9'(f[0]);
			n5 = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'(f[0]);
			ov = (a[7] != m[7]) && (s9[7] != a[7]);
			case (i % 6 + 1)
				1: em = {m[0], m[7:1]};
				2: ea = {m[0], m[7:1]};
				3: begin em = {f[0], m[7:1]}; ef[0] = m[0]; end
				4: begin ea = {f[0], m[7:1]}; ef[0] = m[0]; end
				5: ea = s9[7:0];
				default: em = s9[7:0];
			endcase
			if (i % 6 > 3)
				ef = {s9[7:0] == 8'h0 && f[2], ov ^ s9[7], ov, s9[7:0] == 8'h0, n5[4], s9[8]};
			rd(rr_sbc_pkg::OFS_ACC, {OK, 24'h0, ea});
			rd(rr_sbc_pkg::OFS_FLAGS, {OK, 26'h0, ef});
			rd(rr_sbc_pkg::OFS_MEMDATA, {OK, 24'h0, em});
			rd(rr_sbc_pkg::OFS_PTR, {OK, 28'h0, 4'(i % 16)});
			rd(rr_sbc_pkg::OFS_STAT, {OK, 28'h0, 3'(i % 6 + 1), 1'b0});
		end
		// Refused accesses change nothing
		wr(rr_sbc_pkg::OFS_CMD, 32'h7, ERR);
		wr(rr_sbc_pkg::OFS_STAT, 32'h0, ERR);
		wr(8'h02, 32'h5, ERR);
		rd(8'h18, {ERR, 32'h0});
		rd(rr_sbc_pkg::OFS_ACC, {OK, 24'h0, ea});
		// A cleared low byte lane leaves the register alone but still answers OKAY
		wstrb <= 4'he;
		wr(rr_sbc_pkg::OFS_ACC, 32'h5a, OK);
		wstrb <= 4'hf;
		rd(rr_sbc_pkg::OFS_ACC, {OK, 24'h0, ea});
		// The no-op code is recorded without starting a run
		wr(rr_sbc_pkg::OFS_CMD, 32'h0, OK);
		rd(rr_sbc_pkg::OFS_STAT, {OK, 32'h0});
		// A second reset while idle brings acc, flags and pointer back to their reset values
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(rr_sbc_pkg::OFS_ACC, {OK, 24'h0, rr_sbc_pkg::ACC_RST});
		rd(rr_sbc_pkg::OFS_FLAGS, {OK, 26'h0, rr_sbc_pkg::FLAGS_RST});
		rd(rr_sbc_pkg::OFS_PTR, {OK, 28'h0, rr_sbc_pkg::PTR_RST});
		summarize();
	end
endmodule
